// ### common/supervisor_defs.svh
// Overview of operation
// - reset held while supply low or manual low
// - 200ms extra reset after supply recovers
// - 200ms extra reset after manual release
// - every reset lasts at least full timeout
// - supply dip restarts the timeout counter
// - active-high reset is inverse of active-low
// - fault low on stuck kick until edge
// - watchdog timeout is 1.6 seconds
// - fault output high during reset
// - watchdog timer cleared while reset asserted
// - unconnected kick input disables watchdog
// - chip-select passes only when reset inactive
// - gated chip-select output forced high while reset active
// - ram supply main when above threshold/cell
// - backup-active high when cell feeds ram
// - cell-good high when above cell threshold, forced low while on backup
`ifndef SUPERVISOR_DEFS_SVH
`define SUPERVISOR_DEFS_SVH
`define CLK_HZ            100000000
`define RESET_TIMEOUT_MS  200
`define WATCHDOG_TIMEOUT_MS 1600
`define RESET_CYCLES      ((`CLK_HZ / 1000) * `RESET_TIMEOUT_MS)
`define WATCHDOG_CYCLES   ((`CLK_HZ / 1000) * `WATCHDOG_TIMEOUT_MS)
`define SYNC_ZERO         2'h0
`define SYNC_ONES         2'h3
`define MIN_CYCLES        1
`define SYNC_LANES        6
`define LANE_SUPPLY       0
`define LANE_MANUAL       1
`define LANE_KICK         2
`define LANE_OPEN         3
`define LANE_CELL         4
`define LANE_ABOVE        5
`define LEVEL_LOW         1'b0
`define LEVEL_HIGH        1'b1
`endif

// ### common/supervisor_pkg.sv
package supervisor_pkg;
    typedef enum logic [1:0] {
        ST_HOLD,
        ST_TIMEOUT,
        ST_RUN
    } reset_state_t;
endpackage : supervisor_pkg

// ### verilog/supervisor_reset_watchdog.sv
`include "supervisor_defs.svh"

module supervisor_reset_watchdog
    import supervisor_pkg::*;
#(
    parameter int RESET_CYCLES    = `RESET_CYCLES,
    parameter int WATCHDOG_CYCLES = `WATCHDOG_CYCLES
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic reset_i,
    // supply and manual reset
    input  wire logic supply_low_i,
    input  wire logic manual_reset_n_i,
    // watchdog
    input  wire logic watchdog_kick_in_i,
    input  wire logic watchdog_kick_open_i,
    output logic      watchdog_fault_n_o,
    // resets out
    output logic      reset_n_o,
    output logic      reset_o,
    // chip-select gate
    input  wire logic chip_select_n_i,
    output logic      chip_select_n_o,
    // backup supply
    input  wire logic main_above_cell_i,
    input  wire logic cell_good_threshold_i,
    output logic      ram_from_backup_o,
    output logic      backup_active_o,
    output logic      backup_cell_good_o
);

    // a timeout of zero cycles leaves nothing to count
    if (RESET_CYCLES < `MIN_CYCLES) begin : g_bad_reset_cycles
        $error("reset timeout count must be at least one cycle");
    end
    if (WATCHDOG_CYCLES < `MIN_CYCLES) begin : g_bad_watchdog_cycles
        $error("watchdog timeout count must be at least one cycle");
    end

    localparam int RW    = $clog2(RESET_CYCLES + 1);
    localparam int WW    = $clog2(WATCHDOG_CYCLES + 1);
    localparam int LANES = `SYNC_LANES;

    // preset per lane: supply reads low and kick reads open until inputs settle
    function automatic logic [1:0] lane_preset(input int lane);
        logic [1:0] value;
        value = `SYNC_ZERO;
        if (lane == `LANE_SUPPLY || lane == `LANE_OPEN) begin
            value = `SYNC_ONES;
        end
        return value;
    endfunction : lane_preset

    // any state but run keeps the system in reset
    function automatic logic holding(input reset_state_t st);
        return (st != ST_RUN);
    endfunction : holding

    // every pin input except clock, reset and chip select gathered into one lane vector
    wire [LANES-1:0] raw_in;
    wire [LANES-1:0] synced;

    assign raw_in[`LANE_SUPPLY] = supply_low_i;
    assign raw_in[`LANE_MANUAL] = manual_reset_n_i;
    assign raw_in[`LANE_KICK]   = watchdog_kick_in_i;
    assign raw_in[`LANE_OPEN]   = watchdog_kick_open_i;
    assign raw_in[`LANE_CELL]   = cell_good_threshold_i;
    assign raw_in[`LANE_ABOVE]  = main_above_cell_i;

    // two-flop synchronisers; first stage feeds only the second
    for (genvar lane = 0; lane < LANES; lane++) begin : g_sync
        logic [1:0] stage;

        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                stage <= lane_preset(lane);
            end else begin
                stage <= {stage[0], raw_in[lane]};
            end
        end

        assign synced[lane] = stage[1];
    end

    // synchronised levels under their own names
    wire supply_low = synced[`LANE_SUPPLY];
    wire manual_low = ~synced[`LANE_MANUAL];
    wire kick_level = synced[`LANE_KICK];
    wire kick_open  = synced[`LANE_OPEN];
    wire cell_good  = synced[`LANE_CELL];
    wire main_above = synced[`LANE_ABOVE];
    wire trigger    = supply_low | manual_low;

    // reset sequencer
    reset_state_t  state;
    reset_state_t  next_state;
    logic [RW-1:0] reset_count;
    logic [RW-1:0] next_reset_count;
    wire           reset_done = (reset_count == RW'(RESET_CYCLES - 1));
    wire           counting   = (state == ST_TIMEOUT) && !trigger;

    always_comb begin
        next_state = state;
        case (state)
            ST_HOLD: begin
                if (!trigger) begin
                    next_state = ST_TIMEOUT;
                end
            end
            ST_TIMEOUT: begin
                if (trigger) begin
                    next_state = ST_HOLD;
                end else if (reset_done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (trigger) begin
                    next_state = ST_HOLD;
                end
            end
            default: begin
                next_state = ST_HOLD;
            end
        endcase
    end

    // zeroed whenever not counting, so even a one-cycle trigger earns the full timeout
    assign next_reset_count = counting ? reset_count + RW'(1) : '0;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state <= ST_HOLD;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reset_count <= '0;
        end else begin
            reset_count <= next_reset_count;
        end
    end

    // outputs follow next_state so fault and gate react on the same edge as reset
    wire hold_next    = holding(next_state);
    wire reset_active = holding(state);
    wire next_reset_n = ~hold_next;
    wire next_reset   = hold_next;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reset_n_o <= `LEVEL_LOW;
        end else begin
            reset_n_o <= next_reset_n;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reset_o <= `LEVEL_HIGH;
        end else begin
            reset_o <= next_reset;
        end
    end

    // watchdog
    logic          kick_prev;
    logic [WW-1:0] wd_count;
    logic [WW-1:0] next_wd_count;
    logic          wd_fault;
    logic          next_wd_fault;
    wire           kick_edge  = kick_level ^ kick_prev;
    wire           wd_expired = (wd_count == WW'(WATCHDOG_CYCLES - 1));
    wire           wd_clear   = hold_next | reset_active | kick_edge | kick_open;

    always_comb begin
        next_wd_count = wd_count;
        next_wd_fault = wd_fault;
        if (wd_clear) begin
            next_wd_count = '0;
            next_wd_fault = `LEVEL_LOW;
        end else if (wd_expired) begin
            next_wd_fault = `LEVEL_HIGH;
        end else begin
            next_wd_count = wd_count + WW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            kick_prev <= `LEVEL_LOW;
        end else begin
            kick_prev <= kick_level;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wd_count <= '0;
        end else begin
            wd_count <= next_wd_count;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wd_fault <= `LEVEL_LOW;
        end else begin
            wd_fault <= next_wd_fault;
        end
    end

    // driven from the next value so the fault lifts on the very edge reset asserts
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            watchdog_fault_n_o <= `LEVEL_HIGH;
        end else begin
            watchdog_fault_n_o <= ~next_wd_fault;
        end
    end

    // chip-select gate stays combinational to keep the path short
    assign chip_select_n_o = reset_n_o ? chip_select_n_i : `LEVEL_HIGH;

    // supply selection
    wire on_backup      = supply_low & ~main_above;
    wire next_cell_good = cell_good & ~on_backup;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ram_from_backup_o <= `LEVEL_LOW;
        end else begin
            ram_from_backup_o <= on_backup;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            backup_active_o <= `LEVEL_LOW;
        end else begin
            backup_active_o <= on_backup;
        end
    end

    // cell health only reported in normal mode, so forced low while on backup
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            backup_cell_good_o <= `LEVEL_LOW;
        end else begin
            backup_cell_good_o <= next_cell_good;
        end
    end

endmodule : supervisor_reset_watchdog

// ### verif/supervisor_reset_watchdog_monitor.sv
module supervisor_reset_watchdog_monitor #(
    parameter int RESET_CYCLES    = 20,
    parameter int WATCHDOG_CYCLES = 50
) (
    input wire logic clk_i, reset_i, manual_reset_n_i, watchdog_kick_in_i,
    input wire logic watchdog_kick_open_i, watchdog_fault_n_o, reset_n_o, reset_o,
    input wire logic chip_select_n_i, chip_select_n_o
);
    int   lowcnt;
    int   kcnt;
    logic kprev;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // raw kick edge clears early, so kcnt never falls below the synced count
    always_ff @(posedge clk_i) begin
        kprev  <= watchdog_kick_in_i;
        lowcnt <= (reset_i || reset_n_o) ? 0 : lowcnt + 1;
        kcnt   <= (reset_i || !reset_n_o || kprev != watchdog_kick_in_i) ? 0 : kcnt + 1;
    end
    a_reset_inverse: assert property (reset_o == !reset_n_o)
        else $error("reset outputs differ");
    a_cs_blocked: assert property (!reset_n_o |-> chip_select_n_o)
        else $error("select passed in reset");
    a_cs_passed: assert property (reset_n_o |-> chip_select_n_o == chip_select_n_i)
        else $error("select not passed");
    a_manual_holds: assert property (!manual_reset_n_i [*4] |-> !reset_n_o)
        else $error("reset off with manual low");
    a_min_width: assert property ($rose(reset_n_o) |-> lowcnt >= RESET_CYCLES)
        else $error("reset too short");
    a_fault_in_reset: assert property (!reset_n_o |-> watchdog_fault_n_o)
        else $error("fault in reset");
    a_fault_open: assert property (watchdog_kick_open_i [*3] |-> watchdog_fault_n_o)
        else $error("fault with kick open");
    a_wd_timeout: assert property ($fell(watchdog_fault_n_o) |-> kcnt >= WATCHDOG_CYCLES)
        else $error("fault too early");
endmodule : supervisor_reset_watchdog_monitor

bind supervisor_reset_watchdog supervisor_reset_watchdog_monitor #(
    .RESET_CYCLES(RESET_CYCLES),
    .WATCHDOG_CYCLES(WATCHDOG_CYCLES)
) mon_u (.*);

// ### verif/cpu_partner.sv
module cpu_partner (
    input  wire logic clk_i,
    input  wire logic kick_en_i,
    output logic      kick_o,
    output logic      cs_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] div = 3'h0;
    initial {kick_o, cs_n_o} = 2'h1;
    // kicks well inside the timeout, stops on request
    always @(posedge clk_i) begin
        div <= div + 3'h1;
        cs_n_o <= ~cs_n_o;
        if (kick_en_i && div == 3'h7) kick_o <= ~kick_o;
    end
endmodule : cpu_partner

// ### verif/supervisor_reset_watchdog_bench.sv
module supervisor_reset_watchdog_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, sup = 1'b0, man = 1'b1;
    logic kon = 1'b1, opn = 1'b0, mac = 1'b1, thr = 1'b1;
    wire logic kick, csi, fn, rn, ro, cso, rfb, ba, cg;
    int err_count = 0, num_checks = 0;
    always #5 clk = ~clk;
    supervisor_reset_watchdog #(.RESET_CYCLES(20), .WATCHDOG_CYCLES(50)) dut_u (
        .clk_i(clk), .reset_i(rst), .supply_low_i(sup), .manual_reset_n_i(man),
        .watchdog_kick_in_i(kick), .watchdog_kick_open_i(opn), .watchdog_fault_n_o(fn),
        .reset_n_o(rn), .reset_o(ro), .chip_select_n_i(csi), .chip_select_n_o(cso),
        .main_above_cell_i(mac), .cell_good_threshold_i(thr), .ram_from_backup_o(rfb),
        .backup_active_o(ba), .backup_cell_good_o(cg));
    cpu_partner cpu_u (.clk_i(clk), .kick_en_i(kon), .kick_o(kick), .cs_n_o(csi));
    task chk(input logic s, input logic e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("unexpected t=%0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    task wrap_up;
        if (err_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    task w(input int n);
        repeat (n) @(posedge clk);
    endtask : w
    // bounded wait for release, judged against the shortened timeout
    task span;
        int n;
        n = 0;
        while (rn !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        chk(n > 14 && n < 26, 1'b1);
    endtask : span
    // manual low held long enough for the monitor to see it
    task t_manual;
        man <= 1'b0;
        w(6);
        chk(rn, 1'b0);
        chk(ro, 1'b1);
        chk(cso, 1'b1);
        man <= 1'b1;
        span();
        w(2);
        chk(ro, 1'b0);
        chk(cso, csi);
    endtask : t_manual
    task t_dip;
        w(5);
        sup <= 1'b1;
        w(10);
        sup <= 1'b0;
        w(10);
        sup <= 1'b1; // dip mid-timeout
        w(1);
        sup <= 1'b0;
        w(4);
        span();
    endtask : t_dip
    task t_watchdog;
        w(80);
        chk(fn, 1'b1);
        kon <= 1'b0;
        w(40);
        chk(fn, 1'b1);
        w(20);
        chk(fn, 1'b0);
        kon <= 1'b1;
        w(12);
        chk(fn, 1'b1);
    endtask : t_watchdog
    task t_open;
        opn <= 1'b1;
        kon <= 1'b0;
        w(70);
        chk(fn, 1'b1);
    endtask : t_open
    // fault wired back into manual reset, as a system integrator would
    task t_route;
        int lows;
        lows = 0;
        opn <= 1'b0;
        repeat (90) begin
            @(posedge clk);
            man <= fn;
            if (rn === 1'b0) lows++;
        end
        w(1);
        man <= 1'b1;
        chk(lows > 0, 1'b1);
    endtask : t_route
    task t_backup;
        sup <= 1'b1;
        mac <= 1'b0;
        w(5);
        chk(ba & rfb & ~cg, 1'b1);
        mac <= 1'b1;
        w(5);
        chk(ba | ~cg, 1'b0);
    endtask : t_backup
    initial begin
        w(6);
        rst <= 1'b0;
        w(40);
        t_manual();
        t_dip();
        t_watchdog();
        t_open();
        t_route();
        t_backup();
        wrap_up();
    end
    initial begin
        w(3000);
        err_count++;
        wrap_up();
    end
endmodule : supervisor_reset_watchdog_bench
